// ===== sensor_logging_pkg.sv
// Constants and carrier types shared by the sensor logging controller
package sensor_logging_pkg;
	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] CTRL_OFS  = 8'h00;
	localparam logic [7:0] MODE_OFS  = 8'h04;
	localparam logic [7:0] IVL_OFS   = 8'h08;
	localparam logic [7:0] START_OFS = 8'h0c;
	localparam logic [7:0] RTC_OFS   = 8'h10;
	localparam logic [7:0] STAT_OFS  = 8'h14;
	localparam logic [7:0] ISTAT_OFS = 8'h18;
	localparam logic [7:0] IMASK_OFS = 8'h1c;
	localparam logic [7:0] SAMP_OFS  = 8'h20;
	localparam logic [7:0] STIME_OFS = 8'h24;
	localparam logic [7:0] PWD0_OFS  = 8'h28;
	localparam logic [7:0] PWD2_OFS  = 8'h30;
	localparam logic [7:0] SHELF_OFS = 8'h34;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP  = 1;
	localparam int CTRL_BATT  = 2;
	localparam int IRQ_LOG    = 0;
	localparam int IRQ_TRIG   = 1;
	localparam int IRQ_SHELF  = 2;
	localparam int IRQ_BATT   = 3;
	// ****************************************
	// Reset values and channels
	// ****************************************
	localparam logic [15:0] IVL_RST   = 16'h0001;
	localparam logic [6:0]  MODE_RST  = 7'h08;
	localparam logic [1:0]  CH_TEMP   = 2'h0;
	localparam logic [1:0]  CH_BATT   = 2'h3;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int SEC_NS        = 1000000000;
	localparam int SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
	localparam int IVL_MIN_S     = 1;
	localparam int IVL_MAX_H     = 9;
	localparam int IVL_MAX_S     = IVL_MAX_H * 3600;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_ACTIVE = 3'b001,
		ST_MEAS   = 3'b011,
		ST_WAIT   = 3'b010,
		ST_STORE  = 3'b110,
		ST_BAT    = 3'b100,
		ST_BATW   = 3'b101
	} state_e;
	typedef struct packed {
		logic [3:0] meas;       // Channels to sample: temp, first_sensor_input, second_sensor_input, battery
		logic [1:0] trig_sel;   // Bit0 first input, bit1 second input
		logic       event_mode; // 1 = triggered, 0 = periodic
	} mode_s;
	typedef struct packed {
		logic [31:0] stamp; // Seconds timer at the event
		logic [1:0]  src;   // 0 timer, 1 first input, 2 second input
		logic [1:0]  chan;  // Converter channel
		logic [9:0]  value; // Converter result
	} rec_s;
endpackage : sensor_logging_pkg

// ===== sensor_logging_control.sv
// Logging, timer, converter sharing, battery check, passwords and shelf life
// Functional notes
// R1: Start command loads start time, starts timer
// R2: Log interval from one second to nine hours
// R3: Event mode logs on external trigger
// R4: Trigger select; first input wins when simultaneous
// R5: Configuration picks measurements per event
// R6: Store value with 32-bit timer stamp
// R7: Event mode only after config then start
// R8: One 10-bit converter, logic selects input/reference
// R9: Three independent password sets per area
// R10: Low half gates write, high half both
// R11: Battery type check at power-up
// R12: Reader retriggers battery check after first connection
// R13: Shelf life computed, alarm output on expiry
// R14: Serial host configures, starts and stops logging
// R15: Timer flag logs, measures, stores, returns active
// R16: Event logs when sensor passes threshold
// R17: Passwords never block serial accesses
// R18: RF passwords immediate, serial on field entry
// R19: Interval counter counts seconds, flags, reloads
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module sensor_logging_control
	import sensor_logging_pkg::*;
#(
	parameter int          SEC_CYC  = SEC_CYCLES, // Clock cycles per second
	parameter logic [9:0]  BAT3_LVL = 10'h200     // Battery code at or above: 3V cell
) (
	// Clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	// APB slave
	input  wire logic [7:0]               paddr,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [31:0]              pwdata,
	output var  logic [31:0]              prdata,
	output var  logic                     pready,
	output var  logic                     pslverr,
	// Sensor comparator pins
	input  wire logic                     first_sensor_input,
	input  wire logic                     second_sensor_input,
	// Shared converter
	output var  logic                     adc_start,
	output var  logic [1:0]               adc_sel,
	output var  logic                     adc_ref,
	input  wire logic                     adc_done,
	input  wire logic [9:0]               adc_data,
	// Nonvolatile record port
	output var  logic                     nvm_valid,
	output var  sensor_logging_pkg::rec_s nvm_rec,
	input  wire logic                     nvm_ready,
	// RF side
	input  wire logic                     rf_field,
	input  wire logic                     rf_set_pwd,
	input  wire logic [1:0]               rf_area,
	input  wire logic [31:0]              rf_key,
	output var  logic                     rf_rd_ok,
	output var  logic                     rf_wr_ok,
	// Alarms
	output var  logic                     irq,
	output var  logic                     shelf_alarm
);
	localparam int PW = $clog2(SEC_CYC);

	// ****************************************
	// Functions
	// ****************************************
	// Lowest pending channel
	function automatic logic [1:0] low_bit(input logic [3:0] m);
		logic [1:0] r;
		r = 2'h3;
		for (int i = 3; i >= 0; i--) begin
			if (m[i]) r = 2'(i);
		end
		return r;
	endfunction : low_bit
	// Password half passes when unset or matching
	function automatic logic half_ok(input logic [15:0] p, input logic [15:0] k);
		return (p == 16'h0000) || (p == k);
	endfunction : half_ok
	// Interval kept inside one second .. nine hours
	function automatic logic [15:0] clamp_ivl(input logic [31:0] v);
		if (v < 32'(IVL_MIN_S)) return 16'(IVL_MIN_S);
		if (v > 32'(IVL_MAX_S)) return 16'(IVL_MAX_S);
		return v[15:0];
	endfunction : clamp_ivl

	// ****************************************
	// Register bus
	// ****************************************
	logic        acc, wr, rd_setup, hit;   // Bus qualifiers
	logic        cmd_start, cmd_stop, cmd_batt;
	mode_s       mode_reg, mode_next;      // Logging configuration
	logic [15:0] ivl_reg, ivl_next;        // Interval in seconds
	logic [31:0] start_reg, start_next;    // Start time for timer
	logic [3:0]  istat_reg, istat_next;    // Sticky events
	logic [3:0]  imask_reg, imask_next;    // Event enables
	logic [31:0] shinit_reg, shinit_next;  // Shelf life budget
	logic [31:0] pwd_reg [3];              // Serially written passwords
	logic [31:0] pwd_next [3];
	logic [31:0] prdata_reg, prdata_next;
	logic [3:0]  events;                   // Event pulses from control
	// Control state seen by the bus
	state_e      state_reg, state_next;
	logic [31:0] rtc_reg, rtc_next;
	logic        run_reg, run_next;
	logic        bat3_reg, bat3_next;
	logic        alarm_reg, alarm_next;
	rec_s        rec_reg, rec_next;

	// Decode, command pulses and read mux
	always_comb begin
		acc         = psel && penable;
		wr          = acc && pwrite;
		rd_setup    = psel && !penable;
		hit         = (paddr[1:0] == 2'h0) && (paddr <= SHELF_OFS);
		cmd_start   = wr && (paddr == CTRL_OFS) && pwdata[CTRL_START]; // R14
		cmd_stop    = wr && (paddr == CTRL_OFS) && pwdata[CTRL_STOP];  // R14
		cmd_batt    = wr && (paddr == CTRL_OFS) && pwdata[CTRL_BATT];  // R12
		mode_next   = mode_reg;
		ivl_next    = ivl_reg;
		start_next  = start_reg;
		imask_next  = imask_reg;
		shinit_next = shinit_reg;
		pwd_next    = pwd_reg;
		prdata_next = prdata_reg;
		// Set wins over a write-one clear
		istat_next  = istat_reg | events;
		// Writes are never password gated
		if (wr) begin // R17
			case (paddr)
				MODE_OFS:  mode_next   = mode_s'(pwdata[6:0]); // R5
				IVL_OFS:   ivl_next    = clamp_ivl(pwdata);   // R2
				START_OFS: start_next  = pwdata;
				ISTAT_OFS: istat_next  = (istat_reg & ~pwdata[3:0]) | events;
				IMASK_OFS: imask_next  = pwdata[3:0];
				SHELF_OFS: shinit_next = pwdata;
				default: begin
					if (paddr >= PWD0_OFS && paddr <= PWD2_OFS) begin
						pwd_next[2'(paddr[3:2] - 2'h2)] = pwdata; // R18
					end
				end
			endcase
		end
		// Read data captured in the setup cycle
		if (rd_setup) begin
			case (paddr)
				MODE_OFS:  prdata_next = {25'h0, mode_reg};
				IVL_OFS:   prdata_next = {16'h0, ivl_reg};
				START_OFS: prdata_next = start_reg;
				RTC_OFS:   prdata_next = rtc_reg;
				STAT_OFS:  prdata_next = {26'h0, state_reg, alarm_reg, bat3_reg, run_reg};
				ISTAT_OFS: prdata_next = {28'h0, istat_reg};
				IMASK_OFS: prdata_next = {28'h0, imask_reg};
				SAMP_OFS:  prdata_next = {18'h0, rec_reg.src, rec_reg.chan, rec_reg.value};
				STIME_OFS: prdata_next = rec_reg.stamp;
				SHELF_OFS: prdata_next = shinit_reg;
				default: begin
					if (paddr >= PWD0_OFS && paddr <= PWD2_OFS) begin
						prdata_next = pwd_reg[2'(paddr[3:2] - 2'h2)];
					end else begin
						prdata_next = 32'h0;
					end
				end
			endcase
		end
	end

	// Bus registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_reg   <= mode_s'(MODE_RST);
			ivl_reg    <= IVL_RST;
			start_reg  <= 32'h0;
			istat_reg  <= 4'h0;
			imask_reg  <= 4'h0;
			shinit_reg <= 32'h0;
			pwd_reg    <= '{default: 32'h0};
			prdata_reg <= 32'h0;
		end else begin
			mode_reg   <= mode_next;
			ivl_reg    <= ivl_next;
			start_reg  <= start_next;
			istat_reg  <= istat_next;
			imask_reg  <= imask_next;
			shinit_reg <= shinit_next;
			pwd_reg    <= pwd_next;
			prdata_reg <= prdata_next;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = 1'b1;
	assign pslverr = acc && !hit;
	assign irq     = |(istat_reg & imask_reg);

	// ****************************************
	// Logging control
	// ****************************************
	logic [1:0]  ext_s1, ext_s2, ext_prev; // Trigger pin synchronisers
	logic        fld_s1, fld_s2, fld_prev; // Field pin synchroniser
	logic [PW-1:0] pre_reg, pre_next;      // One-second prescaler
	logic [15:0] icnt_reg, icnt_next;      // Interval down counter
	mode_s       rmode_reg, rmode_next;    // Mode captured at start
	logic [3:0]  todo_reg, todo_next;      // Channels left this event
	logic        pend_reg, pend_next;      // Event waiting for idle path
	logic [1:0]  psrc_reg, psrc_next;      // Source of the pending event
	logic [31:0] shleft_reg, shleft_next;  // Remaining shelf life
	logic [31:0] apwd_reg [3];             // Passwords in force
	logic [31:0] apwd_next [3];
	logic        start_reg2, start_next2;  // Converter start pulse
	logic [1:0]  sel_reg, sel_next;
	logic        rdok_reg, rdok_next, wrok_reg, wrok_next; // RF grants
	logic        sec_tick, flag, trig1, trig2;
	logic [1:0]  rise;

	// Next state of timer, sequencer, shelf life and passwords
	always_comb begin
		state_next  = state_reg;
		rtc_next    = rtc_reg;
		run_next    = run_reg;
		bat3_next   = bat3_reg;
		alarm_next  = alarm_reg;
		rec_next    = rec_reg;
		icnt_next   = icnt_reg;
		rmode_next  = rmode_reg;
		todo_next   = todo_reg;
		pend_next   = pend_reg;
		psrc_next   = psrc_reg;
		shleft_next = shleft_reg;
		apwd_next   = apwd_reg;
		start_next2 = 1'b0;
		sel_next    = sel_reg;
		events      = 4'h0;
		flag        = 1'b0;
		// High half gates all access, low half writes too
		rdok_next = (rf_area != 2'h3) && half_ok(apwd_reg[rf_area][31:16], rf_key[31:16]); // R10
		wrok_next = rdok_next && half_ok(apwd_reg[rf_area][15:0], rf_key[15:0]); // R10
		rise        = ext_s2 & ~ext_prev;
		// Second tick and timer
		sec_tick = (pre_reg == PW'(SEC_CYC - 1));
		pre_next = (sec_tick || cmd_start) ? '0 : PW'(pre_reg + 1'b1);
		if (run_reg && sec_tick) rtc_next = rtc_reg + 32'h1;
		// Periodic interval counter
		if (run_reg && !rmode_reg.event_mode && sec_tick) begin // R19
			if (icnt_reg <= 16'h1) begin
				flag      = 1'b1; // R15
				icnt_next = ivl_reg;
			end else begin
				icnt_next = icnt_reg - 16'h1;
			end
		end
		// Trigger select, first input has priority
		trig1 = rise[0] && rmode_reg.trig_sel[0]; // R4
		trig2 = rise[1] && rmode_reg.trig_sel[1]; // R4
		if (run_reg && rmode_reg.event_mode && (trig1 || trig2)) begin // R3 R16
			flag        = 1'b1;
			events[IRQ_TRIG] = 1'b1;
		end
		if (flag && !pend_reg) begin
			pend_next = 1'b1;
			psrc_next = !rmode_reg.event_mode ? 2'h0 : (trig1 ? 2'h1 : 2'h2); // R4
		end
		// RF password set acts at once; serial copies on field entry
		if (fld_s2 && !fld_prev) apwd_next = pwd_reg; // R18
		if (rf_set_pwd && rf_area != 2'h3) apwd_next[rf_area] = rf_key; // R18 R9
		// Sequencer
		case (state_reg)
			ST_ACTIVE: begin
				if (pend_reg) begin
					pend_next  = 1'b0;
					todo_next  = (rmode_reg.meas == 4'h0) ? 4'h1 : rmode_reg.meas; // R5
					rec_next.stamp = rtc_reg; // R6
					rec_next.src   = psrc_reg;
					state_next = ST_MEAS;
				end
			end
			ST_MEAS: begin
				sel_next    = low_bit(todo_reg); // R8
				start_next2 = 1'b1;
				state_next  = ST_WAIT;
			end
			ST_WAIT: begin
				if (adc_done) begin
					rec_next.chan  = sel_reg;
					rec_next.value = adc_data; // R6
					state_next     = ST_STORE;
				end
			end
			ST_STORE: begin
				if (nvm_ready) begin
					todo_next[rec_reg.chan] = 1'b0;
					// Temperature samples consume shelf life
					if (rec_reg.chan == CH_TEMP && !alarm_reg) begin // R13
						if ({22'h0, rec_reg.value} >= shleft_reg) begin
							shleft_next = 32'h0;
							alarm_next  = 1'b1;
							events[IRQ_SHELF] = 1'b1;
						end else begin
							shleft_next = shleft_reg - {22'h0, rec_reg.value};
						end
					end
					if ((todo_reg & ~(4'h1 << rec_reg.chan)) == 4'h0) begin
						events[IRQ_LOG] = 1'b1;
						state_next = ST_ACTIVE; // R15
					end else begin
						state_next = ST_MEAS;
					end
				end
			end
			ST_BAT: begin
				sel_next    = CH_BATT; // R11
				start_next2 = 1'b1;
				state_next  = ST_BATW;
			end
			ST_BATW: begin
				if (adc_done) begin
					bat3_next  = (adc_data >= BAT3_LVL); // R11
					events[IRQ_BATT] = 1'b1;
					state_next = run_reg ? ST_ACTIVE : ST_IDLE;
				end
			end
			default: ;
		endcase
		// Host commands
		if ((state_reg == ST_IDLE || state_reg == ST_ACTIVE) && cmd_batt) begin
			state_next = ST_BAT; // R12
		end
		if (cmd_start && state_reg != ST_BAT && state_reg != ST_BATW) begin
			rtc_next    = start_reg;  // R1
			rmode_next  = mode_reg;   // R7
			icnt_next   = ivl_reg;    // R2
			run_next    = 1'b1;
			pend_next   = 1'b0;
			shleft_next = shinit_reg;
			alarm_next  = 1'b0;
			state_next  = ST_ACTIVE;
		end
		if (cmd_stop) begin // R14
			run_next  = 1'b0;
			pend_next = 1'b0;
			if (state_reg != ST_BAT && state_reg != ST_BATW) state_next = ST_IDLE;
		end
	end

	// Control registers
	always_ff @(posedge core_clk) begin
		ext_s1 <= {second_sensor_input, first_sensor_input};
		ext_s2 <= ext_s1;
		fld_s1 <= rf_field;
		fld_s2 <= fld_s1;
		if (rst) begin
			state_reg  <= ST_BAT; // R11
			ext_prev   <= 2'h0;
			fld_prev   <= 1'b0;
			pre_reg    <= '0;
			rtc_reg    <= 32'h0;
			run_reg    <= 1'b0;
			bat3_reg   <= 1'b0;
			alarm_reg  <= 1'b0;
			rec_reg    <= '0;
			icnt_reg   <= IVL_RST;
			rmode_reg  <= mode_s'(MODE_RST);
			todo_reg   <= 4'h0;
			pend_reg   <= 1'b0;
			psrc_reg   <= 2'h0;
			shleft_reg <= 32'h0;
			apwd_reg   <= '{default: 32'h0};
			start_reg2 <= 1'b0;
			sel_reg    <= CH_TEMP;
			rdok_reg   <= 1'b0;
			wrok_reg   <= 1'b0;
		end else begin
			state_reg  <= state_next;
			ext_prev   <= ext_s2;
			fld_prev   <= fld_s2;
			pre_reg    <= pre_next;
			rtc_reg    <= rtc_next;
			run_reg    <= run_next;
			bat3_reg   <= bat3_next;
			alarm_reg  <= alarm_next;
			rec_reg    <= rec_next;
			icnt_reg   <= icnt_next;
			rmode_reg  <= rmode_next;
			todo_reg   <= todo_next;
			pend_reg   <= pend_next;
			psrc_reg   <= psrc_next;
			shleft_reg <= shleft_next;
			apwd_reg   <= apwd_next;
			start_reg2 <= start_next2;
			sel_reg    <= sel_next;
			rdok_reg   <= rdok_next;
			wrok_reg   <= wrok_next;
		end
	end

	assign adc_start   = start_reg2;
	assign adc_sel     = sel_reg;
	assign adc_ref     = (sel_reg == CH_BATT); // R8
	assign nvm_valid   = (state_reg == ST_STORE);
	assign nvm_rec     = rec_reg;
	assign rf_rd_ok    = rdok_reg;
	assign rf_wr_ok    = wrok_reg;
	assign shelf_alarm = alarm_reg; // R13
endmodule : sensor_logging_control
`default_nettype wire

// ===== sensor_logging_monitor.sv
// Port checker for the sensor logging controller
`timescale 1ns/10ps
`default_nettype none
module sensor_logging_monitor
	import sensor_logging_pkg::*;
(
	// Clock and reset
	input wire logic                     core_clk,
	input wire logic                     rst,
	// Register bus
	input wire logic [7:0]               paddr,
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pready,
	input wire logic                     pslverr,
	// Converter and record port
	input wire logic                     adc_start,
	input wire logic [1:0]               adc_sel,
	input wire logic                     adc_ref,
	input wire logic                     adc_done,
	input wire logic                     nvm_valid,
	input wire sensor_logging_pkg::rec_s nvm_rec,
	input wire logic                     nvm_ready,
	// RF access
	input wire logic [1:0]               rf_area,
	input wire logic                     rf_rd_ok,
	input wire logic                     rf_wr_ok
);
	// ****************************
	// Checks
	// ****************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// Record offered and not yet taken
	sequence rec_held;
		nvm_valid && !nvm_ready;
	endsequence
	// Battery channel conversion request
	sequence bat_conv;
		adc_start && adc_sel == CH_BATT;
	endsequence
	bus_ready_a: assert property (psel |-> pready) else $error("pready low");
	bad_addr_a: assert property (psel && penable |->
		pslverr == (paddr[1:0] != 2'h0 || paddr > SHELF_OFS)) else $error("pslverr wrong");
	ref_sel_a: assert property (adc_ref == (adc_sel == CH_BATT)) else $error("ref wrong");
	conv_pulse_a: assert property (adc_start |=> !adc_start) else $error("long start");
	rec_hold_a: assert property (rec_held |=> nvm_valid && $stable(nvm_rec))
		else $error("record dropped or changed");
	rec_cause_a: assert property ($rose(nvm_valid) |-> $past(adc_done))
		else $error("record without conversion");
	store_quiet_a: assert property (nvm_valid |-> !adc_start) else $error("start in store");
	bat_check_a: assert property ($fell(rst) |-> ##[0:2] bat_conv)
		else $error("no battery check");
	rf_area_a: assert property (rf_area == 2'h3 |=> !rf_rd_ok && !rf_wr_ok)
		else $error("area three granted");
	rf_write_a: assert property (rf_wr_ok |-> rf_rd_ok) else $error("write without read");
endmodule : sensor_logging_monitor
bind sensor_logging_control sensor_logging_monitor u_mon (.core_clk(core_clk), .rst(rst),
	.paddr(paddr), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.adc_start(adc_start), .adc_sel(adc_sel), .adc_ref(adc_ref), .adc_done(adc_done),
	.nvm_valid(nvm_valid), .nvm_rec(nvm_rec), .nvm_ready(nvm_ready),
	.rf_area(rf_area), .rf_rd_ok(rf_rd_ok), .rf_wr_ok(rf_wr_ok));
`default_nettype wire

// ===== sensor_far_model.sv
// Far-side model: converter answers and record memory handshake
`timescale 1ns/10ps
`default_nettype none
module sensor_far_model (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Converter
	input  wire logic       adc_start,
	output var  logic       adc_done,
	output var  logic [9:0] adc_data,
	// Record memory
	input  wire logic       nvm_valid,
	output var  logic       nvm_ready,
	// Bench controls
	input  wire logic [9:0] sample_val,
	input  wire logic       slow
);
	int cnt;  // Cycles left in a conversion
	int wcnt; // Cycles a record has waited
	// Conversion delay; data toggles outside the done cycle
	always @(posedge core_clk) begin
		if (rst) begin
			cnt <= 0;
			wcnt <= 0;
			adc_done <= 1'b0;
			adc_data <= 10'h155;
			nvm_ready <= 1'b0;
		end else begin
			adc_done <= (cnt == 1);
			adc_data <= (cnt == 1) ? sample_val : ~adc_data;
			if (adc_start) begin
				cnt <= slow ? 6 : 2;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
			// Memory write stalls a while in slow mode
			nvm_ready <= nvm_valid && !nvm_ready && wcnt >= (slow ? 3 : 0);
			wcnt <= (nvm_valid && !nvm_ready) ? wcnt + 1 : 0;
		end
	end
endmodule : sensor_far_model
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the sensor logging controller
`timescale 1ns/10ps
`default_nettype none
module tb;
	import sensor_logging_pkg::*;
	localparam int SC = 20; // Short second for simulation
	// ****************************
	// Signals
	// ****************************
	logic        core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rf_key = 32'h0, prdata, r, st, k;
	logic        trig_a = 1'b0, trig_b = 1'b0, rf_field = 1'b0, rf_set_pwd = 1'b0, slow = 1'b0;
	logic [1:0]  rf_area = 2'h0, adc_sel;
	logic [9:0]  sval = 10'h2a5, adc_data;
	logic        pready, pslverr, adc_start, adc_ref, adc_done, nvm_valid, nvm_ready, e;
	logic        rf_rd_ok, rf_wr_ok, irq, shelf_alarm;
	rec_s        nvm_rec, rc;
	logic [31:0] pw [3] = '{default: 32'h0}; // Passwords in force
	int          seed = 57, miscompares = 0, compares = 0, i;
	int          iv [5];
	always #25 core_clk = ~core_clk;
	sensor_logging_control #(.SEC_CYC(SC)) u_dut (.core_clk(core_clk), .rst(rst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .first_sensor_input(trig_a),
		.second_sensor_input(trig_b), .adc_start(adc_start), .adc_sel(adc_sel),
		.adc_ref(adc_ref), .adc_done(adc_done), .adc_data(adc_data), .nvm_valid(nvm_valid),
		.nvm_rec(nvm_rec), .nvm_ready(nvm_ready), .rf_field(rf_field), .rf_set_pwd(rf_set_pwd),
		.rf_area(rf_area), .rf_key(rf_key), .rf_rd_ok(rf_rd_ok), .rf_wr_ok(rf_wr_ok),
		.irq(irq), .shelf_alarm(shelf_alarm));
	sensor_far_model u_far (.core_clk(core_clk), .rst(rst), .adc_start(adc_start),
		.adc_done(adc_done), .adc_data(adc_data), .nvm_valid(nvm_valid),
		.nvm_ready(nvm_ready), .sample_val(sval), .slow(slow));
	// ****************************
	// Tasks and expectations
	// ****************************
	task automatic stop_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask : check
	// Hang guard: count a mismatch and close
	task automatic hang;
		miscompares++;
		stop_test();
	endtask : hang
	// One bus transfer, result left in r and e
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) hang();
		@(posedge core_clk);
	endtask : apb
	// Poll a status bit, then clear it by writing one
	task automatic wait_ist(input int b);
		int n;
		for (n = 0; n < 400; n++) begin
			apb(1'b0, ISTAT_OFS, 32'h0);
			if (r[b] === 1'b1) break;
		end
		if (n >= 400) hang();
		apb(1'b1, ISTAT_OFS, 32'h1 << b);
	endtask : wait_ist
	// Wait for an accepted record
	task automatic wait_rec;
		int n;
		for (n = 0; n < 2000; n++) begin
			@(posedge core_clk);
			if (nvm_valid === 1'b1 && nvm_ready === 1'b1) break;
		end
		if (n >= 2000) hang();
		rc = nvm_rec;
	endtask : wait_rec
	function automatic logic [31:0] ivl_exp(input int v);
		if (v < IVL_MIN_S) return 32'(IVL_MIN_S);
		if (v > IVL_MAX_S) return 32'(IVL_MAX_S);
		return 32'(v);
	endfunction : ivl_exp
	function automatic logic [1:0] rf_exp(input logic [1:0] a, input logic [31:0] key);
		logic rd;
		if (a == 2'h3) return 2'b00;
		rd = pw[a][31:16] == 16'h0 || pw[a][31:16] == key[31:16];
		return {rd, rd && (pw[a][15:0] == 16'h0 || pw[a][15:0] == key[15:0])};
	endfunction : rf_exp
	task automatic rfchk(input logic [1:0] a, input logic [31:0] key);
		rf_area <= a;
		rf_key <= key;
		repeat (2) @(posedge core_clk);
		check({rf_rd_ok, rf_wr_ok}, rf_exp(a, key), "rf grant");
	endtask : rfchk
	// ****************************
	// Main sequence
	// ****************************
	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		wait_ist(IRQ_BATT);
		apb(1'b0, STAT_OFS, 32'h0);
		check(r[1], 1'b1, "3V battery");
		apb(1'b0, MODE_OFS, 32'h0);
		check(r, {25'h0, MODE_RST}, "mode reset");
		apb(1'b0, 8'h38, 32'h0);
		check(e, 1'b1, "unmapped error");
		check(r, 32'h0, "unmapped read");
		$display("test reset done");
		iv = '{0, 1, IVL_MAX_S, IVL_MAX_S + 1, 0};
		iv[4] = $random(seed) & 32'hffff;
		for (i = 0; i < 5; i++) begin
			apb(1'b1, IVL_OFS, 32'(iv[i]));
			apb(1'b0, IVL_OFS, 32'h0);
			check(r, ivl_exp(iv[i]), "interval");
		end
		sval <= 10'($random(seed)) & 10'h1ff;
		apb(1'b1, CTRL_OFS, 32'h1 << CTRL_BATT);
		wait_ist(IRQ_BATT);
		apb(1'b0, STAT_OFS, 32'h0);
		check(r[1], 1'b0, "1.5V battery");
		$display("test config done");
		st = $random(seed);
		sval <= 10'($random(seed)) | 10'h001;
		apb(1'b1, MODE_OFS, 32'h48);
		apb(1'b1, IVL_OFS, 32'h2);
		apb(1'b1, SHELF_OFS, 32'(sval) + 32'h1);
		apb(1'b1, START_OFS, st);
		apb(1'b1, IMASK_OFS, 32'h1 << IRQ_LOG);
		apb(1'b1, CTRL_OFS, 32'h1 << CTRL_START);
		wait_rec();
		check(rc.stamp, st + 2, "first stamp");
		check({rc.src, rc.chan, rc.value}, {2'h0, CH_TEMP, sval}, "periodic rec");
		wait_rec();
		check({rc.chan, rc.value}, {CH_BATT, sval}, "battery rec");
		check(rc.stamp, st + 2, "same stamp");
		check(shelf_alarm, 1'b0, "shelf left");
		wait_rec();
		check(rc.stamp, st + 4, "reload stamp");
		repeat (3) @(posedge core_clk);
		check(irq, 1'b1, "irq set");
		check(shelf_alarm, 1'b1, "shelf expired");
		apb(1'b1, IMASK_OFS, 32'h0);
		check(irq, 1'b0, "irq masked");
		apb(1'b1, IMASK_OFS, 32'h1 << IRQ_LOG);
		apb(1'b1, ISTAT_OFS, 32'h1 << IRQ_LOG);
		check(irq, 1'b0, "irq cleared");
		apb(1'b1, CTRL_OFS, 32'h1 << CTRL_STOP);
		apb(1'b0, STAT_OFS, 32'h0);
		check(r[0], 1'b0, "stopped");
		$display("test periodic done");
		slow <= 1'b1;
		apb(1'b1, MODE_OFS, 32'h27);
		apb(1'b1, IVL_OFS, 32'd1000);
		trig_a <= 1'b1;
		repeat (30) @(posedge core_clk);
		trig_a <= 1'b0;
		apb(1'b0, ISTAT_OFS, 32'h0);
		check(r[IRQ_TRIG], 1'b0, "no event before start");
		st = $random(seed);
		apb(1'b1, START_OFS, st);
		apb(1'b1, CTRL_OFS, 32'h1 << CTRL_START);
		trig_a <= 1'b1;
		trig_b <= 1'b1;
		wait_rec();
		check({rc.src, rc.chan, rc.value}, {2'h1, 2'h2, sval}, "both inputs");
		check(rc.stamp - st <= 32'h1, 1'b1, "event stamp");
		trig_a <= 1'b0;
		trig_b <= 1'b0;
		repeat (10) @(posedge core_clk);
		trig_b <= 1'b1;
		wait_rec();
		check({rc.src, rc.chan}, {2'h2, 2'h2}, "second input");
		trig_b <= 1'b0;
		slow <= 1'b0;
		$display("test event done");
		k = $random(seed) | 32'h00010001;
		apb(1'b1, PWD0_OFS, k);
		rfchk(2'h0, 32'h0);
		rf_field <= 1'b1;
		repeat (5) @(posedge core_clk);
		pw[0] = k;
		rfchk(2'h0, 32'h0);
		rfchk(2'h0, k);
		rfchk(2'h0, {k[31:16], ~k[15:0]});
		rfchk(2'h3, k);
		rf_area <= 2'h2;
		rf_key <= k ^ 32'h00ff00ff;
		rf_set_pwd <= 1'b1;
		@(posedge core_clk);
		rf_set_pwd <= 1'b0;
		pw[2] = k ^ 32'h00ff00ff;
		rfchk(2'h2, 32'h0);
		for (i = 0; i < 6; i++) begin
			rfchk(2'(i % 4), $random(seed));
		end
		apb(1'b0, PWD0_OFS, 32'h0);
		check(e, 1'b0, "serial no error");
		check(r, k, "serial unblocked");
		$display("test passwords done");
		stop_test();
	end
endmodule : tb
`default_nettype wire
